/* pkg/diag_adc_pkg.sv */
`default_nettype none
package diag_adc_pkg;
   localparam int        SLOTS        = 4;
   localparam int        SEL_W        = 7;
   localparam int        RES_W        = 10;
   localparam int        WORD_W       = 20;
   localparam logic [7:0] ADDR_SLOT_A = 8'h3a;
   localparam logic [7:0] ADDR_SLOT_B = 8'h3b;
   localparam logic [7:0] ADDR_SLOT_C = 8'h3c;
   localparam logic [7:0] ADDR_SLOT_D = 8'h3d;
   localparam int        FLAG_BIT     = 19;
   localparam int        ECHO_LSB     = 10;
   // measurement select codes
   localparam logic [6:0] SEL_UNUSED0  = 7'h00;
   localparam logic [6:0] SEL_GROUND   = 7'h01;
   localparam logic [6:0] SEL_FULLSCL  = 7'h02;
   localparam logic [6:0] SEL_DCS_V    = 7'h03;
   localparam logic [6:0] SEL_DCS_I    = 7'h04;
   localparam logic [6:0] SEL_DCS_R    = 7'h05;
   localparam logic [6:0] SEL_SQUIB    = 7'h06;
   localparam logic [6:0] SEL_VREF     = 7'h07;
   localparam logic [6:0] SEL_VREFMON  = 7'h08;
   localparam logic [6:0] SEL_CORE     = 7'h09;
   localparam logic [6:0] SEL_TEMP     = 7'h0a;
   localparam logic [6:0] SEL_DCS_CH0  = 7'h0b;
   localparam logic [6:0] SEL_DCS_CH8  = 7'h13;
   localparam logic [6:0] SEL_ESR_B    = 7'h14;
   localparam logic [6:0] SEL_ESR_A    = 7'h15;
   localparam logic [6:0] SEL_ESR_C    = 7'h16;
   localparam logic [9:0] RES_NONE     = 10'h000;
   localparam logic [6:0] SEL_RESET    = 7'h00;
   // analog source selector handed to the mux
   typedef enum logic [4:0]
   {
      SRC_NONE, SRC_GROUND, SRC_FULLSCALE, SRC_DCS_V, SRC_DCS_I,
      SRC_DCS_R, SRC_SQUIB, SRC_VREF, SRC_VREFMON, SRC_CORE,
      SRC_TEMP, SRC_DCS_CH, SRC_ESR_B, SRC_ESR_A, SRC_ESR_C
   } mux_source_t;
   typedef struct packed
   {
      mux_source_t source;
      logic [3:0]  channel;
   } mux_select_t;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_CONV = 3'b010,
      ST_DONE = 3'b100
   } conv_state_t;
endpackage : diag_adc_pkg
`default_nettype wire

/* src/diag_select_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module diag_select_decode
   import diag_adc_pkg::*;
(
   // code in
   input  wire logic [SEL_W-1:0] code,
   // mux selection out
   output mux_select_t           sel
);
   wire in_dcs_range = (code >= SEL_DCS_CH0) && (code <= SEL_DCS_CH8);
   wire [6:0] ch_off = code - SEL_DCS_CH0;
   mux_source_t src;
   // unused codes still convert, into a zero result
   assign src =
      (code == SEL_GROUND)  ? SRC_GROUND    :
      (code == SEL_FULLSCL) ? SRC_FULLSCALE :
      (code == SEL_DCS_V)   ? SRC_DCS_V     :
      (code == SEL_DCS_I)   ? SRC_DCS_I     :
      (code == SEL_DCS_R)   ? SRC_DCS_R     :
      (code == SEL_SQUIB)   ? SRC_SQUIB     :
      (code == SEL_VREF)    ? SRC_VREF      :
      (code == SEL_VREFMON) ? SRC_VREFMON   :
      (code == SEL_CORE)    ? SRC_CORE      :
      (code == SEL_TEMP)    ? SRC_TEMP      :
      in_dcs_range          ? SRC_DCS_CH    :
      (code == SEL_ESR_B)   ? SRC_ESR_B     :
      (code == SEL_ESR_A)   ? SRC_ESR_A     :
      (code == SEL_ESR_C)   ? SRC_ESR_C     :
                              SRC_NONE;
   wire [3:0] chan = in_dcs_range ? ch_off[3:0] : 4'h0;
   assign sel = '{source: src, channel: chan};
endmodule : diag_select_decode
`default_nettype wire

/* src/diag_adc_request_queue.sv */
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - four independent slots, one command each
// - slot D at 0x3d, flag/echo/result reply
// - ready bits OR the slot flag pairs
// - flag set on done, cleared by read
// - result held until newer conversion done
// - queued requests run in arrival order
// - queue holds four entries
// - repeat command replaces pending request
// - result goes to the requesting slot
// - codes 03-05 select dc sensor v/i/r
// - codes 01,02,06 ground, fullscale, squib
// - codes 07-0a reference, monitors, temperature
// - codes 0b-13 dc sensor channels 0-8
// - codes 14-16 esr b, a, c voltages
module diag_adc_request_queue
   import diag_adc_pkg::*;
#(
   parameter int DEPTH = SLOTS
)
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // decoded spi command
   input  wire logic              cmd_valid,
   input  wire logic [7:0]        cmd_addr,
   input  wire logic [SEL_W-1:0]  cmd_select,
   output logic [WORD_W-1:0]      cmd_reply,
   output logic                   cmd_hit,
   // converter
   output mux_select_t            conv_sel,
   output logic                   conv_start,
   input  wire logic              conv_done,
   input  wire logic [RES_W-1:0]  conv_data,
   // status
   output logic                   results_ready_ab,
   output logic                   results_ready_cd
);
   // index widths are sized for exactly one entry per slot
   if (DEPTH != SLOTS)
   begin : g_depth_check
      $error("queue depth must equal slot count");
   end
   // ********************************************************
   // command decode
   // ********************************************************
   wire [1:0] slot_idx =
      (cmd_addr == ADDR_SLOT_A) ? 2'd0 :
      (cmd_addr == ADDR_SLOT_B) ? 2'd1 :
      (cmd_addr == ADDR_SLOT_C) ? 2'd2 : 2'd3;
   wire hit = (cmd_addr == ADDR_SLOT_A) || (cmd_addr == ADDR_SLOT_B) ||
              (cmd_addr == ADDR_SLOT_C) || (cmd_addr == ADDR_SLOT_D);
   wire req = cmd_valid && hit;
   assign cmd_hit = hit;
   // ********************************************************
   // slot storage
   // ********************************************************
   logic [SEL_W-1:0] code_reg   [SLOTS];
   logic [RES_W-1:0] result_reg [SLOTS];
   logic [SLOTS-1:0] flag_reg;
   logic [SLOTS-1:0] pend_reg;
   // fifo of slot indices; a slot is in it at most once, so 4 suffice
   logic [1:0]       fifo_reg [DEPTH];
   logic [2:0]       count_reg;
   conv_state_t      state_reg;
   logic [1:0]       cur_reg;
   logic [WORD_W-1:0] reply_reg;
   wire start_now = (state_reg == ST_IDLE) && (count_reg != 3'd0);
   wire finish    = (state_reg == ST_CONV) && conv_done;
   wire dup       = req && pend_reg[slot_idx];
   wire push      = req && !pend_reg[slot_idx];
   wire [2:0] count_pop = start_now ? count_reg - 3'd1 : count_reg;
   // ********************************************************
   // queue and state machine
   // ********************************************************
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         count_reg <= 3'd0;
         pend_reg  <= '0;
         state_reg <= ST_IDLE;
         cur_reg   <= 2'd0;
         for (int i = 0; i < DEPTH; i++)
            fifo_reg[i] <= 2'd0;
      end
      else
      begin
         if (start_now)
         begin
            for (int i = 0; i < DEPTH - 1; i++)
               fifo_reg[i] <= fifo_reg[i+1];
            cur_reg <= fifo_reg[0];
         end
         if (push)
            fifo_reg[count_pop[1:0]] <= slot_idx;
         count_reg <= count_pop + (push ? 3'd1 : 3'd0);
         pend_reg  <= (pend_reg
                      & ~(start_now ? (4'b0001 << fifo_reg[0]) : 4'b0000))
                      | (push ? (4'b0001 << slot_idx) : 4'b0000);
         case (state_reg)
            ST_IDLE: if (start_now) state_reg <= ST_CONV;
            ST_CONV: if (conv_done) state_reg <= ST_DONE;
            ST_DONE: state_reg <= ST_IDLE;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end
   // ********************************************************
   // slot registers and reply
   // ********************************************************
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         flag_reg  <= '0;
         reply_reg <= '0;
         for (int i = 0; i < SLOTS; i++)
         begin
            code_reg[i]   <= SEL_RESET;
            result_reg[i] <= RES_NONE;
         end
      end
      else
      begin
         if (req)
         begin
            // bits 18:17 of the reply always read as zero
            reply_reg <= {flag_reg[slot_idx], 2'b00, code_reg[slot_idx],
                          result_reg[slot_idx]};
            code_reg[slot_idx] <= cmd_select;
         end
         for (int i = 0; i < SLOTS; i++)
         begin
            // completion wins over a read clear in the same cycle
            if (finish && cur_reg == 2'(i))
            begin
               result_reg[i] <= conv_data;
               flag_reg[i]   <= 1'b1;
            end
            else if (req && slot_idx == 2'(i))
               flag_reg[i] <= 1'b0;
         end
      end
   end
   // a rewrite of the running slot retargets the mux live
   diag_select_decode u_dec
   (
      .code (code_reg[cur_reg]),
      .sel  (conv_sel)
   );
   assign conv_start = (state_reg == ST_CONV);
   assign cmd_reply  = reply_reg;
   assign results_ready_ab = flag_reg[0] | flag_reg[1];
   assign results_ready_cd = flag_reg[2] | flag_reg[3];
   // ********************************************************
   // assertions
   // ********************************************************
   property p_ready_ab;
      @(posedge clk) disable iff (rst)
      finish && !cur_reg[1] |=> results_ready_ab;
   endproperty
   a_ready_ab: assert property (p_ready_ab) else $error("ab ready");
   property p_flag_set;
      @(posedge clk) disable iff (rst)
      finish |=> flag_reg[$past(cur_reg)];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag set");
   property p_res_hold;
      @(posedge clk) disable iff (rst)
      !finish |=> $stable(result_reg[3]);
   endproperty
   a_res_hold: assert property (p_res_hold) else $error("result");
   property p_count_max;
      @(posedge clk) disable iff (rst)
      count_reg <= 3'd4;
   endproperty
   a_count_max: assert property (p_count_max) else $error("count");
   property p_dup;
      @(posedge clk) disable iff (rst)
      dup && !start_now |=> count_reg == $past(count_reg);
   endproperty
   a_dup: assert property (p_dup) else $error("dup grew");
   sequence s_start;
      state_reg == ST_IDLE && count_reg != 3'd0;
   endsequence
   property p_order;
      @(posedge clk) disable iff (rst)
      s_start |=> cur_reg == $past(fifo_reg[0]);
   endproperty
   a_order: assert property (p_order) else $error("order");
   property p_reply;
      @(posedge clk) disable iff (rst)
      req |=> reply_reg[FLAG_BIT] == $past(flag_reg[slot_idx]);
   endproperty
   a_reply: assert property (p_reply) else $error("reply");
   property p_result_slot;
      @(posedge clk) disable iff (rst)
      finish |=> result_reg[$past(cur_reg)] == $past(conv_data);
   endproperty
   a_result_slot: assert property (p_result_slot) else $error("slot");
   property p_ready_cd;
      @(posedge clk) disable iff (rst)
      finish && cur_reg[1] |=> results_ready_cd;
   endproperty
   a_ready_cd: assert property (p_ready_cd) else $error("cd ready");
   property p_flag_clear;
      @(posedge clk) disable iff (rst)
      req && !(finish && cur_reg == slot_idx) |=> !flag_reg[$past(slot_idx)];
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("clear");
   property p_code_take;
      @(posedge clk) disable iff (rst)
      req |=> code_reg[$past(slot_idx)] == $past(cmd_select);
   endproperty
   a_code_take: assert property (p_code_take) else $error("code");
endmodule : diag_adc_request_queue
`default_nettype wire

/* tb/conv_model.sv */
`timescale 1ns/1ps
`default_nettype none
module conv_model
   import diag_adc_pkg::*;
(
   // converter handshake
   input  wire logic          clk,
   input  wire logic          start,
   input  wire mux_select_t   sel,
   input  wire logic [3:0]    dly,
   output logic               done,
   output logic [RES_W-1:0]   data
);
   logic [3:0] cnt_reg;
   always_ff @(posedge clk)
   begin
      done    <= 1'b0;
      // idle data toggles so a stale result never looks valid
      data    <= ~data;
      cnt_reg <= start ? cnt_reg + 4'h1 : 4'h0;
      if (start && cnt_reg == dly)
      begin
         done <= 1'b1;
         data <= {1'b0, sel};
      end
   end
endmodule : conv_model
`default_nettype wire

/* tb/test_diag_adc_request_queue.sv */
`timescale 1ns/1ps
`default_nettype none
module test_diag_adc_request_queue
   import diag_adc_pkg::*;
;
   logic              clk, rst, cmd_valid, cmd_hit, conv_start, conv_done;
   logic              results_ready_ab, results_ready_cd;
   logic [7:0]        cmd_addr;
   logic [SEL_W-1:0]  cmd_select, prev;
   logic [WORD_W-1:0] cmd_reply, keep;
   logic [RES_W-1:0]  conv_data;
   logic [3:0]        dly;
   mux_select_t       conv_sel;
   int                fail_count = 0, checks_done = 0, n_done = 0, n0;
   diag_adc_request_queue #(.DEPTH(SLOTS)) dut_u (.clk(clk), .rst(rst),
      .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_select(cmd_select),
      .cmd_reply(cmd_reply), .cmd_hit(cmd_hit), .conv_sel(conv_sel),
      .conv_start(conv_start), .conv_done(conv_done), .conv_data(conv_data),
      .results_ready_ab(results_ready_ab), .results_ready_cd(results_ready_cd));
   conv_model conv_u (.clk(clk), .start(conv_start), .sel(conv_sel),
      .dly(dly), .done(conv_done), .data(conv_data));
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk)
      if (conv_done === 1'b1) n_done <= n_done + 1;
   // ****************
   // host access tasks
   // ****************
   task automatic check(string n, logic [WORD_W-1:0] seen, exp);
      checks_done++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask : check
   task automatic send(logic [7:0] a, logic [SEL_W-1:0] c);
      cmd_valid  <= 1'b1;
      cmd_addr   <= a;
      cmd_select <= c;
      @(posedge clk);
   endtask : send
   task automatic idle(int n);
      cmd_valid <= 1'b0;
      repeat (n) @(posedge clk);
   endtask : idle
   task automatic wait_rdy(logic [1:0] m);
      for (int i = 0; i < 300; i++)
      begin
         if (({results_ready_ab, results_ready_cd} & m) != 2'b00) break;
         @(posedge clk);
      end
      check("ready wait",
            20'(({results_ready_ab, results_ready_cd} & m) != 2'b00),
            20'h1);
   endtask : wait_rdy
   function automatic logic [9:0] exp_res(logic [6:0] c);
      logic [4:0] s;
      s = (c >= 7'h01 && c <= 7'h0a) ? c[4:0] :
          (c >= 7'h0b && c <= 7'h13) ? SRC_DCS_CH :
          (c >= 7'h14 && c <= 7'h16) ? c[4:0] - 5'h08 : SRC_NONE;
      return {1'b0, s, (s == SRC_DCS_CH) ? c[3:0] - 4'hb : 4'h0};
   endfunction : exp_res
   // read a slot and compare flag, echoed code and result
   task automatic rd(logic [7:0] a, logic [6:0] c, logic f, logic [6:0] e);
      logic [9:0] r;
      r = exp_res(e);
      send(a, c);
      idle(2);
      check("reply", cmd_reply, {f, 2'b00, e, r});
   endtask : rd
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : print_verdict
   initial
   begin
      #200000;
      fail_count++;
      print_verdict;
   end
   initial
   begin
      rst <= 1'b1; cmd_valid <= 1'b0; cmd_addr <= 8'h00;
      cmd_select <= 7'h00; dly <= 4'h2;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      idle(1);
      send(ADDR_SLOT_D, 7'h00);
      idle(2);
      check("reset reply", cmd_reply, 20'h00000);
      prev = 7'h00;
      for (int c = 1; c <= 8'h18; c++)
      begin
         wait_rdy(2'b01);
         rd(ADDR_SLOT_D, c[6:0], 1'b1, prev);
         prev = c[6:0];
      end
      $display("test codes done");
      wait_rdy(2'b01);
      dly <= 4'h8;
      rd(ADDR_SLOT_D, 7'h0a, 1'b1, 7'h18);
      send(ADDR_SLOT_D, 7'h0a);
      idle(2);
      check("reread", cmd_reply, {1'b0, 2'b00, 7'h0a, exp_res(7'h18)});
      check("ready cd", {19'h0, results_ready_cd}, 20'h0);
      idle(40);
      $display("test flag done");
      n0 = n_done;
      send(ADDR_SLOT_D, 7'h0b);
      send(ADDR_SLOT_A, 7'h0c);
      send(ADDR_SLOT_C, 7'h0d);
      send(ADDR_SLOT_B, 7'h0e);
      idle(1);
      wait_rdy(2'b01);
      check("ready ab", {19'h0, results_ready_ab}, 20'h0);
      wait_rdy(2'b10);
      check("order", WORD_W'(n_done - n0), 20'h2);
      idle(50);
      check("count", WORD_W'(n_done - n0), 20'h4);
      rd(ADDR_SLOT_A, 7'h00, 1'b1, 7'h0c);
      rd(ADDR_SLOT_B, 7'h00, 1'b1, 7'h0e);
      rd(ADDR_SLOT_C, 7'h00, 1'b1, 7'h0d);
      rd(ADDR_SLOT_D, 7'h00, 1'b1, 7'h0b);
      idle(60);
      $display("test queue done");
      n0 = n_done;
      send(ADDR_SLOT_A, 7'h0c);
      send(ADDR_SLOT_B, 7'h0d);
      send(ADDR_SLOT_B, 7'h0f);
      send(ADDR_SLOT_C, 7'h10);
      idle(60);
      check("replace", WORD_W'(n_done - n0), 20'h3);
      rd(ADDR_SLOT_B, 7'h00, 1'b1, 7'h0f);
      keep = cmd_reply;
      n0 = n_done;
      send(8'h3e, 7'h01);
      check("hit", {19'h0, cmd_hit}, 20'h0);
      idle(20);
      check("ignored", cmd_reply, keep);
      check("no conv", WORD_W'(n_done - n0), 20'h1);
      $display("test replace done");
      print_verdict;
   end
endmodule : test_diag_adc_request_queue
`default_nettype wire
